// [tlrs_top.sv]
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module tlrs_top #(
    parameter logic [31:0] RECON_CYC = tlrs_pkg::RECON_DEF
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // interrupt
    output logic irq
);
    import tlrs_pkg::*;

    typedef struct packed {
        logic awrdy;
        logic wrdy;
        logic bv;
        logic [1:0] br;
        logic arrdy;
        logic rv;
        logic [1:0] rr;
        logic [31:0] rd;
        logic irq;
        logic aw_have;
        logic w_have;
        logic [4:0] aw_idx;
        logic [31:0] wd;
        logic [3:0] ws;
        logic [7:0] imask;
        logic [7:0] istat;
        logic [7:0] stat;
        logic [7:0] diag;
        logic [7:0] phi;
        logic [7:0] plo;
        logic [10:0] ptr;
        logic [15:0] data;
        logic [7:0] sub;
        logic [7:0] cfg;
        logic [7:0] probe;
        logic [7:0] node;
        logic [7:0] setup_first;
        logic [7:0] setup_second;
        logic [7:0] busctl;
        logic [7:0] count;
    } tlrs_st_t;

    tlrs_st_t s, s_nxt;
    logic [7:0] ram [0:2047];
    logic [1:0] ram_we;
    logic [10:0] ram_a0;
    logic [10:0] ram_a1;
    logic [7:0] ram_d0;
    logic [7:0] ram_d1;
    logic wr_fire;
    logic [4:0] ar_idx;
    logic [7:0] nx_id;
    logic nid_stb;
    logic recon_stb;
    logic wide;
    logic [10:0] a_lo;
    logic [10:0] a_hi;

    tlrs_seq #(
        .RECON_CYC(RECON_CYC)
    ) u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(s.node != 8'h00),
        .successor_node_number(nx_id),
        .nid_stb(nid_stb),
        .recon_stb(recon_stb)
    );

    assign wide = s.busctl[B_WIDE];
    assign ar_idx = araddr[6:2];
    assign wr_fire = s.aw_have && s.w_have && !s.bv;
    // wide access: bit 0 of the pointer swaps the byte lanes
    assign a_lo = {s.ptr[10:1], s.ptr[0]};
    assign a_hi = {s.ptr[10:1], ~s.ptr[0]};

    function automatic logic [15:0] ram_word(input logic [10:0] p, input logic w);
        if (w) begin
            ram_word = {ram[{p[10:1], ~p[0]}], ram[p]};
        end else begin
            ram_word = {8'h00, ram[p]};
        end
    endfunction

    function automatic logic [10:0] ptr_step(input logic [10:0] p, input logic w);
        ptr_step = p + (w ? 11'h002 : 11'h001);
    endfunction

    always_comb begin
        s_nxt = s;
        ram_we = 2'b00;
        ram_a0 = a_lo;
        ram_a1 = a_hi;
        ram_d0 = s.wd[7:0];
        ram_d1 = s.wd[15:8];
        // answers taken by the master
        if (s.bv && bready) begin
            s_nxt.bv = 1'b0;
        end
        if (s.rv && rready) begin
            s_nxt.rv = 1'b0;
        end
        // pending write, once both address and data are held
        if (wr_fire) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bv = 1'b1;
            s_nxt.br = (s.aw_idx > IDX_ISTAT) ? RESP_SLVERR : RESP_OKAY;
            if (s.ws[0]) begin
                case (s.aw_idx)
                    IDX_STAT: s_nxt.imask = s.wd[7:0] & IMASK_BITS;
                    IDX_DIAG: begin
                        if (s.wd[7:0] == CMD_CLR_FLAGS) begin
                            s_nxt.stat[B_RECON] = 1'b0;
                            s_nxt.stat[B_POR] = 1'b0;
                        end
                    end
                    IDX_PHI: s_nxt.phi = s.wd[7:0] & PHI_BITS;
                    IDX_PLO: begin
                        s_nxt.plo = s.wd[7:0];
                        s_nxt.ptr = {s.phi[2:0], s.wd[7:0]};
                        if (s.phi[B_RDDATA]) begin
                            s_nxt.data = ram_word({s.phi[2:0], s.wd[7:0]}, wide);
                        end
                    end
                    IDX_DATA: begin
                        ram_we = wide ? {s.ws[1], 1'b1} : 2'b01;
                        if (s.phi[B_AUTOINC]) begin
                            s_nxt.ptr = ptr_step(s.ptr, wide);
                        end
                    end
                    IDX_SUB: s_nxt.sub = s.wd[7:0] & SUB_BITS;
                    IDX_CFG: begin
                        s_nxt.cfg = s.wd[7:0];
                        s_nxt.sub[1:0] = s.wd[1:0];
                    end
                    IDX_IND: begin
                        case (s.sub[2:0])
                            SA_PROBE: s_nxt.probe = s.wd[7:0];
                            SA_NODE: s_nxt.node = s.wd[7:0];
                            SA_SETUP_FIRST: s_nxt.setup_first = s.wd[7:0];
                            SA_SETUP_SECOND: s_nxt.setup_second = s.wd[7:0];
                            SA_BUSCTL: s_nxt.busctl = s.wd[7:0];
                            SA_COUNT: s_nxt.count = s.wd[7:0];
                            // index 3 is the zero-only test register, no effect
                            default: s_nxt.count = s.count;
                        endcase
                    end
                    default: s_nxt.imask = s.imask;
                endcase
            end
        end
        // write channels
        if (awvalid && s.awrdy) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.aw_idx = awaddr[6:2];
        end
        if (wvalid && s.wrdy) begin
            s_nxt.w_have = 1'b1;
            s_nxt.wd = wdata;
            s_nxt.ws = wstrb;
        end
        // read channel, with read side effects
        if (arvalid && s.arrdy) begin
            s_nxt.rv = 1'b1;
            s_nxt.rr = RESP_OKAY;
            s_nxt.rd = 32'h0;
            case (ar_idx)
                IDX_STAT: s_nxt.rd[7:0] = s.stat;
                IDX_DIAG: begin
                    s_nxt.rd[7:0] = s.diag;
                    s_nxt.diag = s.diag & (8'h01 << B_NEWNX);
                end
                IDX_PHI: s_nxt.rd[7:0] = s.phi;
                IDX_PLO: s_nxt.rd[7:0] = s.plo;
                IDX_DATA: begin
                    s_nxt.rd[15:0] = s.data;
                    if (s.phi[B_AUTOINC]) begin
                        s_nxt.ptr = ptr_step(s.ptr, wide);
                        s_nxt.data = ram_word(ptr_step(s.ptr, wide), wide);
                    end
                end
                IDX_SUB: s_nxt.rd[7:0] = s.sub & SUB_BITS;
                IDX_CFG: s_nxt.rd[7:0] = {s.cfg[7:2], s.sub[1:0]};
                IDX_IND: begin
                    case (s.sub[2:0])
                        SA_PROBE: s_nxt.rd[7:0] = s.probe;
                        SA_NODE: s_nxt.rd[7:0] = s.node;
                        SA_SETUP_FIRST: s_nxt.rd[7:0] = s.setup_first;
                        SA_NEXT: begin
                            s_nxt.rd[7:0] = nx_id;
                            s_nxt.diag[B_NEWNX] = 1'b0;
                        end
                        SA_SETUP_SECOND: s_nxt.rd[7:0] = s.setup_second;
                        SA_BUSCTL: s_nxt.rd[7:0] = s.busctl;
                        SA_COUNT: s_nxt.rd[7:0] = s.count;
                        default: s_nxt.rd[7:0] = 8'h00;
                    endcase
                end
                IDX_ISTAT: begin
                    s_nxt.rd[7:0] = s.istat;
                    s_nxt.istat = 8'h00;
                end
                default: s_nxt.rr = RESP_SLVERR;
            endcase
        end
        // hardware events last, so a set wins over a clear
        if (recon_stb) begin
            s_nxt.diag[B_SELFREC] = 1'b1;
            s_nxt.stat[B_RECON] = 1'b1;
            s_nxt.istat[B_RECON] = 1'b1;
        end
        if (nid_stb) begin
            s_nxt.diag[B_NEWNX] = 1'b1;
            s_nxt.istat[B_NEWNX] = 1'b1;
        end
        s_nxt.awrdy = !s_nxt.aw_have && !s_nxt.bv;
        s_nxt.wrdy = !s_nxt.w_have && !s_nxt.bv;
        s_nxt.arrdy = !s_nxt.rv;
        s_nxt.irq = |(s_nxt.istat & s_nxt.imask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.stat <= STAT_RST;
        end else begin
            s <= s_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (ram_we[0]) begin
            ram[wide ? ram_a0 : s.ptr] <= ram_d0;
        end
        if (ram_we[1]) begin
            ram[ram_a1] <= ram_d1;
        end
    end

    assign awready = s.awrdy;
    assign wready = s.wrdy;
    assign bvalid = s.bv;
    assign bresp = s.br;
    assign arready = s.arrdy;
    assign rvalid = s.rv;
    assign rresp = s.rr;
    assign rdata = s.rd;
    assign irq = s.irq;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence both_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence resp_up;
        bvalid && bresp == RESP_OKAY;
    endsequence
    sequence rd_taken;
        arvalid && arready;
    endsequence

    chk_wr_answer: assert property (
        (both_taken and (awaddr[6:2] <= IDX_ISTAT)) |-> ##2 resp_up)
        else $error("write response missing");
    chk_rd_answer: assert property (
        (arvalid && arready) |=> rvalid)
        else $error("read response missing");
    chk_sub_zero: assert property (
        s.sub[6:4] == 3'h0)
        else $error("index bits 6..4 not zero");
    chk_ptr_load: assert property (
        (wr_fire && s.aw_idx == IDX_PLO && s.ws[0])
        |=> s.ptr == {s.phi[2:0], $past(s.wd[7:0])})
        else $error("low write did not load pointer");
    chk_selfrec_set: assert property (
        recon_stb |=> s.diag[B_SELFREC])
        else $error("self reconfig flag not set");
    chk_irq_recon: assert property (
        (recon_stb && s.imask[B_RECON] && !(wr_fire && s.aw_idx == IDX_STAT))
        |=> irq)
        else $error("unmasked event gave no interrupt");
    chk_rd_slverr: assert property (
        (rd_taken and (araddr[6:2] > IDX_ISTAT))
        |=> (rvalid && rresp == RESP_SLVERR && rdata == 32'h0))
        else $error("out of map read not refused");
    chk_next_read: assert property (
        (rd_taken and (araddr[6:2] == IDX_IND && s.sub[2:0] == SA_NEXT))
        |=> rdata[7:0] == $past(nx_id))
        else $error("successor_node_number read returned wrong value");
    chk_test_ignored: assert property (
        (wr_fire && s.aw_idx == IDX_IND && s.sub[2:0] == SA_NEXT)
        |=> ($stable(s.probe) && $stable(s.node) && $stable(s.setup_first) && $stable(s.count)))
        else $error("test register write changed state");
    chk_wide_step: assert property (
        (wr_fire && s.aw_idx == IDX_DATA && s.ws[0] && s.phi[B_AUTOINC] && wide
         && !(arvalid && arready)) |=> s.ptr == $past(s.ptr) + 11'h002)
        else $error("wide data write did not step pointer by two");
    chk_cmd_clear: assert property (
        (wr_fire && s.aw_idx == IDX_DIAG && s.ws[0] && s.wd[7:0] == CMD_CLR_FLAGS
         && !recon_stb) |=> !s.stat[B_RECON])
        else $error("clear flags command left recon set");
endmodule // tlrs_top
`default_nettype wire

// [tlrs_pkg.sv]
`default_nettype none
package tlrs_pkg;
    // host register indices; byte address is four times the index
    localparam logic [4:0] IDX_STAT = 5'h00;
    localparam logic [4:0] IDX_DIAG = 5'h01;
    localparam logic [4:0] IDX_PHI = 5'h02;
    localparam logic [4:0] IDX_PLO = 5'h03;
    localparam logic [4:0] IDX_DATA = 5'h04;
    localparam logic [4:0] IDX_SUB = 5'h05;
    localparam logic [4:0] IDX_CFG = 5'h06;
    localparam logic [4:0] IDX_IND = 5'h07;
    localparam logic [4:0] IDX_ISTAT = 5'h08;
    // indirect indices at location 7
    localparam logic [2:0] SA_PROBE = 3'h0;
    localparam logic [2:0] SA_NODE = 3'h1;
    localparam logic [2:0] SA_SETUP_FIRST = 3'h2;
    localparam logic [2:0] SA_NEXT = 3'h3;
    localparam logic [2:0] SA_SETUP_SECOND = 3'h4;
    localparam logic [2:0] SA_BUSCTL = 3'h5;
    localparam logic [2:0] SA_COUNT = 3'h6;
    // field positions
    localparam int B_RECON = 2;
    localparam int B_NEWNX = 1;
    localparam int B_POR = 4;
    localparam int B_SELFREC = 7;
    localparam int B_RDDATA = 7;
    localparam int B_AUTOINC = 6;
    localparam int B_WIDE = 7;
    // write masks and reset values
    localparam logic [7:0] IMASK_BITS = 8'h9F;
    localparam logic [7:0] PHI_BITS = 8'hCF;
    localparam logic [7:0] SUB_BITS = 8'h8F;
    localparam logic [7:0] STAT_RST = 8'h91;
    localparam logic [7:0] CMD_CLR_FLAGS = 8'h08;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // sequencer timing
    localparam int CLK_MHZ = 200;
    localparam int PC_MHZ = 20;
    localparam int EXEC_MHZ = 10;
    localparam int DIV_PC = CLK_MHZ / PC_MHZ;
    localparam logic [3:0] DIV_LAST = 4'(DIV_PC - 1);
    localparam int ROM_WORDS = 544;
    localparam logic [9:0] PC_LAST = 10'(ROM_WORDS - 1);
    localparam logic [31:0] RECON_DEF = 32'h000F4240;
    typedef enum logic [1:0] {
        OP_EXEC = 2'b00,
        OP_NOP = 2'b01,
        OP_JMP = 2'b10,
        OP_SETNX = 2'b11
    } tlrs_op_t;
    typedef enum logic {
        PH_OP = 1'b0,
        PH_IMM = 1'b1
    } tlrs_ph_t;
endpackage
`default_nettype wire

// [tlrs_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module tlrs_seq #(
    parameter logic [31:0] RECON_CYC = tlrs_pkg::RECON_DEF
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control and results
    input wire logic run,
    output logic [7:0] successor_node_number,
    output logic nid_stb,
    output logic recon_stb
);
    import tlrs_pkg::*;

    typedef struct packed {
        logic [3:0] div;
        tlrs_ph_t ph;
        logic [9:0] pc;
        logic [7:0] ir_op;
        logic [7:0] ir_imm;
        logic ir_ok;
        logic [7:0] wait_cnt;
        logic [31:0] tmr;
        logic [7:0] nx;
        logic nstb;
        logic rstb;
    } tlrs_sq_t;

    tlrs_sq_t s, s_nxt;
    logic tick;
    logic [9:0] fpc;
    logic [9:0] tgt;

    // microprogram store, 544 words of 8 bits
    function automatic logic [7:0] rom(input logic [9:0] a);
        case (a)
            10'h000: rom = 8'hC0;
            10'h001: rom = 8'h01;
            10'h002: rom = 8'h40;
            10'h003: rom = 8'h10;
            10'h004: rom = 8'h80;
            default: rom = 8'h00;
        endcase
    endfunction

    function automatic logic [9:0] pc_inc(input logic [9:0] p);
        pc_inc = (p >= PC_LAST) ? 10'h000 : p + 10'h001;
    endfunction

    assign tgt = {s.ir_op[1:0], s.ir_imm};
    assign tick = (s.div == DIV_LAST);

    always_comb begin
        s_nxt = s;
        fpc = s.pc;
        s_nxt.nstb = 1'b0;
        s_nxt.rstb = 1'b0;
        s_nxt.div = tick ? 4'h0 : s.div + 4'h1;
        if (!run) begin
            s_nxt.tmr = 32'h0;
            s_nxt.pc = 10'h000;
            s_nxt.ph = PH_OP;
            s_nxt.ir_ok = 1'b0;
            // a stopped core must not resume inside an old wait loop
            s_nxt.wait_cnt = 8'h00;
        end else if (s.tmr >= RECON_CYC - 32'h1) begin
            s_nxt.tmr = 32'h0;
            s_nxt.rstb = 1'b1;
            s_nxt.pc = 10'h000;
            s_nxt.ph = PH_OP;
            s_nxt.ir_ok = 1'b0;
            s_nxt.wait_cnt = 8'h00;
        end else begin
            s_nxt.tmr = s.tmr + 32'h1;
            if (tick && s.ph == PH_IMM) begin
                s_nxt.ir_imm = rom(s.pc);
                s_nxt.pc = pc_inc(s.pc);
                s_nxt.ph = PH_OP;
                s_nxt.ir_ok = 1'b1;
            end else if (tick && s.wait_cnt != 8'h00) begin
                s_nxt.wait_cnt = s.wait_cnt - 8'h01;
            end else if (tick) begin
                // execute slot, every second pc tick (10 MHz)
                if (s.ir_ok) begin
                    case (tlrs_op_t'(s.ir_op[7:6]))
                        OP_NOP: s_nxt.wait_cnt = s.ir_imm;
                        OP_JMP: fpc = tgt;
                        OP_SETNX: begin
                            s_nxt.nx = s.ir_imm;
                            s_nxt.nstb = 1'b1;
                        end
                        default: fpc = s.pc;
                    endcase
                end
                s_nxt.ir_ok = 1'b0;
                if (!(s.ir_ok && s.ir_op[7:6] == OP_NOP && s.ir_imm != 8'h00)) begin
                    s_nxt.ir_op = rom(fpc);
                    s_nxt.pc = pc_inc(fpc);
                    s_nxt.ph = PH_IMM;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= s_nxt;
        end
    end

    assign successor_node_number = s.nx;
    assign nid_stb = s.nstb;
    assign recon_stb = s.rstb;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_pc_hold_nop: assert property (
        (s.wait_cnt != 8'h00 && s_nxt.rstb == 1'b0 && run) |=> $stable(s.pc))
        else $error("pc moved during wait loop");
    chk_recon_pc: assert property (
        (run && s.tmr >= RECON_CYC - 32'h1) |=> (s.rstb && s.pc == 10'h000))
        else $error("timer expiry did not clear pc");
    chk_tick_gap: assert property (
        tick |=> !tick [*8])
        else $error("pc tick too frequent");
    chk_jump_load: assert property (
        (tick && s.ph == PH_OP && s.wait_cnt == 8'h00 && s.ir_ok
         && s.ir_op[7:6] == OP_JMP && !s_nxt.rstb && run)
        |=> s.pc == pc_inc($past(tgt)))
        else $error("jump target not loaded");
endmodule // tlrs_seq
`default_nettype wire

// [tlrs_host.sv]
`timescale 1ns/1ps
`default_nettype none
// axi4-lite host: one write and one read at a time, response ready held high
module tlrs_host (
    // clock
    input wire logic aclk,
    // write side
    output logic [31:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // read side
    output logic [31:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    output logic rready
);
    localparam int LIMIT = 64;
    initial begin
        awaddr = '0;
        awvalid = 1'b0;
        wdata = '0;
        wstrb = '0;
        wvalid = 1'b0;
        bready = 1'b1;
        araddr = '0;
        arvalid = 1'b0;
        rready = 1'b1;
    end
    task automatic timed_out();
        tlrs_top_test.fails++;
        tlrs_top_test.report_and_stop();
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (n < LIMIT) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                n = LIMIT + 1;
            end
        end
        if (n == LIMIT) timed_out();
    endtask
    task automatic rd(input logic [31:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        while (n < LIMIT) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) n = LIMIT + 1;
        end
        if (n == LIMIT) timed_out();
    endtask
endmodule // tlrs_host
`default_nettype wire

// [tlrs_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("[ERR] %s expected %h seen %h", nm, (e), (g)); \
    end \
end
module tlrs_top_test;
    import tlrs_pkg::*;
    localparam logic [7:0] WMASK [7] = '{8'hFF, 8'h00, 8'hDF, 8'h00, 8'hBF, 8'h3F, 8'hFF};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    int fails = 0;
    int checks_done = 0;
    integer seed = 32'h88B3;
    logic [33:0] exp_q[$];
    logic [33:0] e_m;
    always #2.5 aclk = ~aclk;
    tlrs_top #(.RECON_CYC(32'h190)) i_tlrs_top (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq)
    );
    tlrs_host i_tlrs_host (
        .aclk(aclk),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rvalid(rvalid), .rready(rready)
    );
    // read results are matched against the oldest note
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready) begin
            e_m = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3_FFFF_FFFF;
            `CHK("read", e_m, {rresp, rdata})
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic w(input logic [4:0] i, input logic [15:0] d);
        i_tlrs_host.wr({25'h0, i, 2'h0}, {16'h0, d}, resp);
        `CHK("bresp", RESP_OKAY, resp)
    endtask
    task automatic r(input logic [4:0] i, input logic [15:0] d);
        exp_q.push_back({RESP_OKAY, 16'h0, d});
        i_tlrs_host.rd({25'h0, i, 2'h0});
    endtask
    task automatic wi(input logic [2:0] sa, input logic [7:0] d);
        w(IDX_SUB, {13'h0, sa});
        w(IDX_IND, {8'h0, d});
    endtask
    task automatic ri(input logic [2:0] sa, input logic [7:0] d);
        w(IDX_SUB, {13'h0, sa});
        r(IDX_IND, {8'h0, d});
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(negedge aclk);
        `CHK("irq", e, irq)
    endtask
    initial begin
        logic [7:0] v [7];
        int k;
        int n;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        r(IDX_STAT, 16'h0091);
        r(IDX_DIAG, 16'h0000);
        r(IDX_PHI, 16'h0000);
        r(IDX_ISTAT, 16'h0000);
        irq_is(1'b0);
        // undefined bits written as zero throughout
        w(IDX_SUB, 16'h008B);
        r(IDX_SUB, 16'h008B);
        r(IDX_CFG, 16'h0003);
        w(IDX_CFG, 16'h0000);
        r(IDX_SUB, 16'h0088);
        for (k = 0; k < 7; k++) begin
            v[k] = 8'($random(seed)) & WMASK[k];
            if (WMASK[k] != 8'h00) wi(3'(k), v[k]);
        end
        for (k = 0; k < 7; k++) begin
            if (WMASK[k] != 8'h00) ri(3'(k), v[k]);
        end
        wi(SA_NEXT, 8'h00);
        ri(SA_NEXT, 8'h00);
        ri(SA_NODE, 8'h00);
        // high pointer before low; the second wide low write at 0x10 reuses the held high
        w(IDX_PHI, 16'h0045);
        w(IDX_PLO, 16'h0010);
        w(IDX_DATA, 16'h00A5);
        w(IDX_DATA, 16'h005A);
        // the low register reads back what was written, not the stepped pointer
        r(IDX_PLO, 16'h0010);
        w(IDX_PHI, 16'h00C5);
        w(IDX_PLO, 16'h0010);
        r(IDX_DATA, 16'h00A5);
        r(IDX_DATA, 16'h005A);
        r(IDX_PHI, 16'h00C5);
        wi(SA_BUSCTL, 8'h80);
        w(IDX_PHI, 16'h00C5);
        w(IDX_PLO, 16'h0011);
        r(IDX_DATA, 16'hA55A);
        w(IDX_PLO, 16'h0010);
        r(IDX_DATA, 16'h5AA5);
        w(IDX_PHI, 16'h0045);
        w(IDX_PLO, 16'h0020);
        w(IDX_DATA, 16'hBEEF);
        w(IDX_PHI, 16'h00C5);
        w(IDX_PLO, 16'h0020);
        r(IDX_DATA, 16'hBEEF);
        wi(SA_BUSCTL, 8'h00);
        // out of map
        exp_q.push_back({RESP_SLVERR, 32'h0});
        i_tlrs_host.rd(32'h0000_0024);
        i_tlrs_host.wr(32'h0000_003C, 32'h0, resp);
        `CHK("bresp", RESP_SLVERR, resp)
        // run the sequencer past its jump and one timer expiry
        w(IDX_STAT, 16'h0006);
        wi(SA_NODE, 8'h2A);
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(negedge aclk);
            n++;
        end
        if (n == 2000) begin
            fails++;
            report_and_stop();
        end
        repeat (600) @(posedge aclk);
        wi(SA_NODE, 8'h00);
        w(IDX_STAT, 16'h0000);
        irq_is(1'b0);
        w(IDX_STAT, 16'h0004);
        irq_is(1'b1);
        r(IDX_ISTAT, 16'h0006);
        irq_is(1'b0);
        r(IDX_DIAG, 16'h0082);
        r(IDX_DIAG, 16'h0002);
        ri(SA_NEXT, 8'h01);
        r(IDX_DIAG, 16'h0000);
        r(IDX_STAT, 16'h0095);
        w(IDX_DIAG, 16'h0008);
        r(IDX_STAT, 16'h0081);
        r(IDX_ISTAT, 16'h0000);
        report_and_stop();
    end
endmodule // tlrs_top_test
`default_nettype wire
